/* uoed_cfg.svh */
// constants for the out endpoint descriptor block
`ifndef UOED_CFG_SVH
`define UOED_CFG_SVH
`define UOED_OFF_CONFIG 3'h0
`define UOED_OFF_X_BASE 3'h1
`define UOED_OFF_X_COUNT 3'h2
`define UOED_OFF_SPARE_LO 3'h3
`define UOED_OFF_SPARE_HI 3'h4
`define UOED_OFF_Y_BASE 3'h5
`define UOED_OFF_Y_COUNT 3'h6
`define UOED_OFF_SIZE 3'h7
`define UOED_BIT_IE 2
`define UOED_BIT_STALL 3
`define UOED_BIT_DOUBLE_BUFFER_ENABLE 4
`define UOED_BIT_TOGGLE 5
`define UOED_BIT_ISO 6
`define UOED_BIT_BME 7
`define UOED_BIT_NAK 7
`define UOED_CONFIG_RESET 8'h00
`define UOED_MAX_COUNT 7'h40
`define UOED_NUM_EP 3
`endif

/* uoed_pkg.sv */
// types for the out endpoint descriptor block
package uoed_pkg;
   typedef logic [7:0] uoed_byte_t;
   typedef logic [10:0] uoed_addr_t;
   typedef enum {UOED_IDLE, UOED_FETCH, UOED_WAIT, UOED_WRITE, UOED_DONE} uoed_state_e;
endpackage

/* uoed_mem_if.sv */
// port bundle between the engine and the descriptor store
`timescale 1ns/1ps
interface uoed_mem_if;
   logic we;
   logic [4:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   modport master (output we, output addr, output wdata, input rdata);
   modport store (input we, input addr, input wdata, output rdata);
endinterface

/* uoed_store.sv */
// descriptor store: 32 bytes holding three eight-byte records, plus a cpu port
`timescale 1ns/1ps
module uoed_store #(
   parameter int DEPTH = 32
) (
   input wire logic clk_in, // system clock
   uoed_mem_if.store eng, // engine side
   input wire logic cpu_we_in, // cpu write strobe
   input wire logic [4:0] cpu_addr_in, // cpu byte address
   input wire logic [7:0] cpu_wdata_in, // cpu write data
   output logic [7:0] cpu_rdata_out // cpu read data, registered
);
   import uoed_pkg::*;
   logic [7:0] mem [DEPTH];
   logic [7:0] eng_q;
   logic [7:0] cpu_q;

   // sram has no reset; contents are undefined until software writes them
   always_ff @(posedge clk_in) begin
      if (eng.we) begin
         mem[eng.addr] <= eng.wdata;
      end
      if (cpu_we_in && !(eng.we && eng.addr == cpu_addr_in)) begin
         mem[cpu_addr_in] <= cpu_wdata_in; // engine wins a same-byte collision
      end
      eng_q <= mem[eng.addr];
      cpu_q <= mem[cpu_addr_in];
   end

   assign eng.rdata = eng_q;
   assign cpu_rdata_out = cpu_q;
endmodule // uoed_store

/* uoed_top.sv */
// out endpoint descriptor block for endpoints 1 to 3 with its buffer engine
`timescale 1ns/1ps
`include "uoed_cfg.svh"
module uoed_top (
   input wire logic CLK_IN, // 25 MHz system clock
   input wire logic ARST_N_IN, // async reset, active low
   input wire logic CPU_WE_IN, // cpu descriptor write strobe
   input wire logic [4:0] CPU_ADDR_IN, // cpu byte address, record n at 8*(n-1)
   input wire uoed_pkg::uoed_byte_t CPU_WDATA_IN, // cpu write data
   output uoed_pkg::uoed_byte_t CPU_RDATA_OUT, // cpu read data, one cycle later
   input wire logic OUT_REQ_IN, // pulse: host out token for endpoint
   input wire logic [1:0] OUT_EP_IN, // endpoint number 1..3
   input wire logic [6:0] OUT_LEN_IN, // received packet length
   input wire logic OUT_OK_IN, // packet arrived without error
   output logic OUT_BUSY_OUT, // engine busy, request not taken
   output logic OUT_ACK_OUT, // pulse: packet accepted
   output logic OUT_NAK_OUT, // pulse: buffer full or endpoint disabled
   output logic OUT_STALL_OUT, // pulse: endpoint stalled
   output uoed_pkg::uoed_addr_t BUF_ADDR_OUT, // start address of chosen buffer
   output logic BUF_VALID_OUT, // pulse: buffer address valid
   output logic EP_IRQ_OUT, // pulse: transaction completion interrupt
   output logic [1:0] EP_IRQ_NUM_OUT // endpoint of the interrupt
);
   import uoed_pkg::*;

   // engine-side port of the descriptor store
   uoed_mem_if mem_if ();

   // endpoint 0 is outside this block; only out records 1..3 sit in sram
   uoed_store #(.DEPTH(32)) u_store (
      .clk_in(CLK_IN),
      .eng(mem_if),
      .cpu_we_in(CPU_WE_IN),
      .cpu_addr_in(CPU_ADDR_IN),
      .cpu_wdata_in(CPU_WDATA_IN),
      .cpu_rdata_out(CPU_RDATA_OUT)
   );

   // engine state and the descriptor fields captured during the fetches
   uoed_state_e state, next_state;
   logic [1:0] ep, next_ep;
   logic [2:0] step, next_step;
   uoed_byte_t cfg, next_cfg;
   uoed_byte_t base, next_base;
   logic [6:0] len, next_len;
   logic ok, next_ok;
   logic use_y, next_use_y;
   logic ack, next_ack;
   logic nak, next_nak;
   logic stall, next_stall;
   logic bvld, next_bvld;
   logic irq, next_irq;
   uoed_addr_t baddr, next_baddr;

   // record byte address from endpoint and offset
   function automatic logic [4:0] rec_addr(input logic [1:0] e, input logic [2:0] off);
      logic [1:0] idx;
      idx = e - 2'h1;
      rec_addr = {idx, off};
   endfunction

   // next-state logic of the transaction engine
   always_comb begin
      next_state = state;
      next_ep = ep;
      next_step = step;
      next_cfg = cfg;
      next_base = base;
      next_len = len;
      next_ok = ok;
      next_use_y = use_y;
      next_baddr = baddr;
      next_ack = 1'b0;
      next_nak = 1'b0;
      next_stall = 1'b0;
      next_bvld = 1'b0;
      next_irq = 1'b0;
      mem_if.we = 1'b0;
      mem_if.addr = rec_addr(ep, `UOED_OFF_CONFIG);
      mem_if.wdata = cfg;
      case (state)
         UOED_IDLE: begin
            // endpoint 0 and out-of-range numbers are ignored
            if (OUT_REQ_IN && OUT_EP_IN != 2'h0) begin
               next_ep = OUT_EP_IN;
               // longer packets are clipped so the count field never overflows
               next_len = (OUT_LEN_IN > `UOED_MAX_COUNT) ? `UOED_MAX_COUNT : OUT_LEN_IN;
               next_ok = OUT_OK_IN;
               next_step = 3'h0;
               next_state = UOED_FETCH;
            end
         end
         UOED_FETCH: begin
            // base and count steps get their address from the override below
            mem_if.addr = rec_addr(ep, `UOED_OFF_CONFIG);
            next_state = UOED_WAIT;
         end
         UOED_WAIT: begin
            // read data is one cycle behind the address
            if (step == 3'h0) begin
               next_cfg = mem_if.rdata;
               if (!mem_if.rdata[`UOED_BIT_BME]) begin
                  next_nak = 1'b1;
                  next_state = UOED_IDLE;
               end else if (mem_if.rdata[`UOED_BIT_STALL]) begin
                  next_stall = 1'b1; // bit left set for cpu to clear
                  next_state = UOED_IDLE;
               end else begin
                  next_use_y = mem_if.rdata[`UOED_BIT_DOUBLE_BUFFER_ENABLE] & mem_if.rdata[`UOED_BIT_TOGGLE];
                  next_step = 3'h1;
                  next_state = UOED_FETCH;
               end
            end else if (step == 3'h1) begin
               next_base = mem_if.rdata; // base byte is only read, never written back
               next_step = 3'h2;
               next_state = UOED_FETCH;
            end else begin
               if (mem_if.rdata[`UOED_BIT_NAK] || !ok) begin
                  next_nak = !mem_if.rdata[`UOED_BIT_NAK] ? 1'b0 : 1'b1;
                  next_state = UOED_IDLE;
               end else begin
                  next_baddr = {base, 3'b000};
                  next_bvld = 1'b1;
                  next_state = UOED_WRITE;
               end
            end
         end
         UOED_WRITE: begin
            // mark buffer full with the received count
            mem_if.we = 1'b1;
            mem_if.addr = rec_addr(ep, use_y ? `UOED_OFF_Y_COUNT : `UOED_OFF_X_COUNT);
            mem_if.wdata = {1'b1, len};
            next_cfg = cfg ^ (8'h01 << `UOED_BIT_TOGGLE);
            next_state = UOED_DONE;
         end
         UOED_DONE: begin
            // only the config byte is rewritten; base bytes stay as the cpu set them
            mem_if.we = 1'b1;
            mem_if.addr = rec_addr(ep, `UOED_OFF_CONFIG);
            mem_if.wdata = cfg;
            next_ack = 1'b1;
            next_irq = cfg[`UOED_BIT_IE];
            next_state = UOED_IDLE;
         end
         default: begin
            next_state = UOED_IDLE;
         end
      endcase
      // pick the base entry address for the fetch of step 1 and the count entry address for step 2
      if (state == UOED_FETCH && step == 3'h1) begin
         mem_if.addr = rec_addr(ep, use_y ? `UOED_OFF_Y_BASE : `UOED_OFF_X_BASE);
      end else if (state == UOED_FETCH && step == 3'h2) begin
         mem_if.addr = rec_addr(ep, use_y ? `UOED_OFF_Y_COUNT : `UOED_OFF_X_COUNT);
      end
   end

   // engine registers
   always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         state <= UOED_IDLE;
         ep <= 2'h1;
         step <= 3'h0;
         cfg <= `UOED_CONFIG_RESET;
         base <= 8'h00;
         len <= 7'h00;
         ok <= 1'b0;
         use_y <= 1'b0;
         baddr <= 11'h000;
         ack <= 1'b0;
         nak <= 1'b0;
         stall <= 1'b0;
         bvld <= 1'b0;
         irq <= 1'b0;
      end else begin
         state <= next_state;
         ep <= next_ep;
         step <= next_step;
         cfg <= next_cfg;
         base <= next_base;
         len <= next_len;
         ok <= next_ok;
         use_y <= next_use_y;
         baddr <= next_baddr;
         ack <= next_ack;
         nak <= next_nak;
         stall <= next_stall;
         bvld <= next_bvld;
         irq <= next_irq;
      end
   end

   // outputs; a cpu write racing the engine on one record is the cpu's hazard
   assign OUT_BUSY_OUT = (state != UOED_IDLE);

   // answer pulses come straight from flip-flops, one cycle each
   assign OUT_ACK_OUT = ack;
   assign OUT_NAK_OUT = nak;
   assign OUT_STALL_OUT = stall;

   // buffer start and interrupt; the endpoint number holds until the next request
   assign BUF_ADDR_OUT = baddr;
   assign BUF_VALID_OUT = bvld;
   assign EP_IRQ_OUT = irq;
   assign EP_IRQ_NUM_OUT = ep;
endmodule // uoed_top

/* uoed_props.sv */
// port assertions for the out endpoint descriptor block
`timescale 1ns/1ps
module uoed_props (
   input wire logic CLK_IN, // clock
   input wire logic ARST_N_IN, // reset
   input wire logic OUT_REQ_IN, // request
   input wire logic [1:0] OUT_EP_IN, // endpoint
   input wire logic OUT_BUSY_OUT, // busy
   input wire logic OUT_ACK_OUT, // accept
   input wire logic OUT_NAK_OUT, // refuse
   input wire logic OUT_STALL_OUT, // stall
   input wire uoed_pkg::uoed_addr_t BUF_ADDR_OUT, // buffer start
   input wire logic BUF_VALID_OUT, // start valid
   input wire logic EP_IRQ_OUT // interrupt
);
   import uoed_pkg::*;
   default clocking cb @(posedge CLK_IN);
   endclocking
   default disable iff (!ARST_N_IN);
   // a request counts only when idle and aimed at a real endpoint
   sequence s_take;
      OUT_REQ_IN && !OUT_BUSY_OUT && OUT_EP_IN != 2'h0;
   endsequence
   sequence s_busy_run;
      OUT_BUSY_OUT ##[1:10] !OUT_BUSY_OUT;
   endsequence
   chk_take_busy: assert property (s_take |=> s_busy_run)
      else $error("busy window wrong");
   chk_addr_align: assert property (BUF_VALID_OUT |-> BUF_ADDR_OUT[2:0] == 3'h0)
      else $error("buffer start not aligned");
   chk_addr_hold: assert property (!BUF_VALID_OUT |-> $stable(BUF_ADDR_OUT))
      else $error("buffer start moved");
   chk_valid_ack: assert property (BUF_VALID_OUT |-> ##2 OUT_ACK_OUT)
      else $error("no accept after buffer start");
   chk_irq_ack: assert property (EP_IRQ_OUT |-> OUT_ACK_OUT)
      else $error("interrupt without accept");
   chk_one_answer: assert property ($onehot0({OUT_ACK_OUT, OUT_NAK_OUT, OUT_STALL_OUT}))
      else $error("two answers at once");
   chk_stall_time: assert property (OUT_STALL_OUT |-> $past(OUT_REQ_IN && !OUT_BUSY_OUT, 3))
      else $error("stall at wrong time");
   chk_ack_time: assert property (OUT_ACK_OUT |-> $past(OUT_REQ_IN && !OUT_BUSY_OUT, 9))
      else $error("accept at wrong time");
endmodule // uoed_props
bind uoed_top uoed_props u_props (.CLK_IN(CLK_IN), .ARST_N_IN(ARST_N_IN), .OUT_REQ_IN(OUT_REQ_IN),
   .OUT_EP_IN(OUT_EP_IN), .OUT_BUSY_OUT(OUT_BUSY_OUT), .OUT_ACK_OUT(OUT_ACK_OUT), .OUT_NAK_OUT(OUT_NAK_OUT),
   .OUT_STALL_OUT(OUT_STALL_OUT), .BUF_ADDR_OUT(BUF_ADDR_OUT), .BUF_VALID_OUT(BUF_VALID_OUT),
   .EP_IRQ_OUT(EP_IRQ_OUT));

/* uoed_host.sv */
// stand-in for the host side: delivers out packets to the engine
`timescale 1ns/1ps
module uoed_host (
   input wire logic clk_in, // clock
   input wire logic busy_in, // engine busy
   output logic req_out, // request pulse
   output logic [1:0] ep_out, // endpoint
   output logic [6:0] len_out, // length
   output logic ok_out // packet clean
);
   logic active = 1'b0;
   initial begin
      req_out = 1'b0;
      ep_out = 2'h1;
      len_out = 7'h55;
      ok_out = 1'b0;
   end
   // between packets the length and ok lines wander so stale data is never taken for real
   always @(negedge clk_in) begin
      if (!active) begin
         len_out <= ~len_out;
         ok_out <= ~ok_out;
      end
   end
   // one packet: wait for idle, then a single-cycle pulse
   task automatic send(input logic [1:0] ep, input logic [6:0] len, input logic ok, output logic hung);
      int n = 0;
      active = 1'b1;
      @(negedge clk_in);
      while (busy_in && n < 20) begin
         n++;
         @(negedge clk_in);
      end
      hung = busy_in;
      req_out = 1'b1;
      ep_out = ep;
      len_out = len;
      ok_out = ok;
      @(negedge clk_in);
      req_out = 1'b0;
      active = 1'b0;
   endtask
endmodule // uoed_host

/* testbench.sv */
// self-checking bench for the out endpoint descriptor block
`timescale 1ns/1ps
module testbench;
   import uoed_pkg::*;
   logic clk = 1'b0, arst_n = 1'b0, we = 1'b0, req, ok, busy, ack, nak, stall, valid, irq, hung;
   logic [4:0] addr = 5'h00;
   logic [1:0] ep, irq_num;
   logic [6:0] len;
   uoed_byte_t wdata = 8'h00, rdata, rnd = 8'h55, b, y;
   uoed_addr_t baddr;
   logic [3:0] resp_q[$];
   logic [1:0] irq_q[$];
   logic pkt_ok = 1'b1;
   uoed_addr_t addr_q[$];
   int bad_count = 0, checks_done = 0;
   always #20 clk = ~clk;
   uoed_top dut (.CLK_IN(clk), .ARST_N_IN(arst_n), .CPU_WE_IN(we), .CPU_ADDR_IN(addr), .CPU_WDATA_IN(wdata),
      .CPU_RDATA_OUT(rdata), .OUT_REQ_IN(req), .OUT_EP_IN(ep), .OUT_LEN_IN(len), .OUT_OK_IN(ok),
      .OUT_BUSY_OUT(busy), .OUT_ACK_OUT(ack), .OUT_NAK_OUT(nak), .OUT_STALL_OUT(stall),
      .BUF_ADDR_OUT(baddr), .BUF_VALID_OUT(valid), .EP_IRQ_OUT(irq), .EP_IRQ_NUM_OUT(irq_num));
   uoed_host host (.clk_in(clk), .busy_in(busy), .req_out(req), .ep_out(ep), .len_out(len), .ok_out(ok));
   function automatic uoed_byte_t lfsr(input uoed_byte_t v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction
   task automatic cmp_data(input string what, input logic [10:0] exp, input logic [10:0] got);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic cmp_resp(input logic [3:0] exp, input logic [3:0] got);
      cmp_data("answer", {7'h00, exp}, {7'h00, got});
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic wr(input logic [4:0] a, input uoed_byte_t d);
      @(negedge clk);
      we = 1'b1;
      addr = a;
      wdata = d;
      @(negedge clk);
      we = 1'b0;
   endtask
   task automatic rd(input logic [4:0] a, input uoed_byte_t exp, input string what);
      @(negedge clk);
      addr = a;
      @(negedge clk);
      cmp_data(what, {3'h0, exp}, {3'h0, rdata});
   endtask
   // answer code is {irq, ack, nak, stall}; the engine must go idle in bounded time
   task automatic pkt(input logic [1:0] e, input logic [6:0] l, input logic [3:0] r, input logic v,
      input uoed_addr_t a);
      int n = 0;
      if (r != 4'h0) resp_q.push_back(r);
      if (r[3]) irq_q.push_back(e);
      if (v) addr_q.push_back(a);
      host.send(e, l, pkt_ok, hung);
      while (busy && n < 20) begin
         n++;
         @(negedge clk);
      end
      if (hung || busy) begin
         bad_count++;
         end_sim();
      end
   endtask
   // outputs are read mid-cycle, well away from the edge that makes them
   always @(negedge clk) begin
      if (ack || nak || stall) cmp_resp(resp_q.size() ? resp_q.pop_front() : 4'h0, {irq, ack, nak, stall});
      if (valid) cmp_data("buffer start", addr_q.size() ? addr_q.pop_front() : 11'h7FF, baddr);
      if (irq) cmp_data("irq ep", {9'h000, irq_q.size() ? irq_q.pop_front() : 2'h0}, {9'h000, irq_num});
   end
   initial begin
      repeat (6) @(posedge clk);
      @(negedge clk);
      arst_n = 1'b1;
      rnd = lfsr(rnd);
      b = rnd;
      wr(5'h01, b);
      wr(5'h02, 8'h00);
      wr(5'h00, 8'h84);
      rd(5'h01, b, "x base");
      pkt(2'h1, 7'h40, 4'hC, 1'b1, {b, 3'h0});
      rd(5'h02, 8'hC0, "x count");
      rd(5'h00, 8'hA4, "config");
      rd(5'h01, b, "x base kept");
      rnd = lfsr(rnd);
      pkt(2'h1, {1'b0, rnd[5:0]}, 4'h2, 1'b0, 11'h000);
      wr(5'h08, 8'h00);
      pkt(2'h2, 7'h01, 4'h2, 1'b0, 11'h000);
      wr(5'h10, 8'h88);
      wr(5'h12, 8'h00);
      pkt(2'h3, 7'h01, 4'h1, 1'b0, 11'h000);
      rd(5'h10, 8'h88, "stall kept");
      rnd = lfsr(rnd);
      y = rnd;
      rnd = lfsr(rnd);
      wr(5'h0D, y);
      wr(5'h0E, 8'h00);
      wr(5'h09, rnd);
      wr(5'h0A, 8'h00);
      wr(5'h08, 8'hB0);
      pkt(2'h2, 7'h05, 4'h4, 1'b1, {y, 3'h0});
      rd(5'h0E, 8'h85, "y count");
      rd(5'h08, 8'h90, "double config");
      pkt(2'h2, 7'h00, 4'h4, 1'b1, {rnd, 3'h0});
      wr(5'h02, 8'h00);
      pkt_ok = 1'b0;
      pkt(2'h1, 7'h03, 4'h0, 1'b0, 11'h000);
      pkt_ok = 1'b1;
      rd(5'h02, 8'h00, "count after bad");
      rd(5'h00, 8'hA4, "config after bad");
      pkt(2'h0, 7'h03, 4'h0, 1'b0, 11'h000);
      pkt(2'h1, 7'h7F, 4'hC, 1'b1, {b, 3'h0});
      rd(5'h02, 8'hC0, "clipped count");
      rd(5'h00, 8'h84, "config toggled back");
      wr(5'h03, rnd);
      rd(5'h03, rnd, "spare");
      repeat (2) @(negedge clk);
      cmp_data("pending", 11'h000, 11'(resp_q.size() + addr_q.size() + irq_q.size()));
      end_sim();
   end
endmodule // testbench
